// ===== design/matrix_i2c_slave.sv
// Operation
// - Transfer: start, address with direction, command byte, data bytes, stop.
// - Start is SDA falling with SCL high; stop is SDA rising.
// - SDA is released whenever no transfer is under way.
// - One bit per SCL pulse; SDA only changes while SCL is low.
// - Ninth clock is acknowledge; receiver holds SDA low through SCL high.
// - Device acknowledges written bytes; master acknowledges read bytes.
// - SCL is input only; SDA is input plus pull-low open drain.
// - Direction bit after address: zero writes, one reads.
// - Address upper bits are 101, lower four come from straps.
// - Each strap is a two-bit code; high strap gives bits 3..2.
// - First byte after write address is stored as the pointer.
// - First data byte goes to the register the pointer selects.
// - Further data bytes go to successive registers as pointer advances.
// - Pointer advances per byte, holds at 05 (font advances) and 7F.
// - Reads return the pointed register and advance the pointer likewise.
// - Eight digit bytes in two planes; either or both planes writable.
// - Primary at 20-23, alternate 40-43, both 60-63 reading zero.
// - Blink disabled: scan uses the primary plane only.
// - Blink enabled: scan alternates planes with the blink phase.
// - Digit bits 6..0 pick one of 128 font characters.
// - Digit bit 7 inverts the selected font pattern.
`timescale 1ns/1ps
`include "matrix_i2c_defs.svh"
module matrix_i2c_slave
  import matrix_i2c_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  input  wire logic [1:0] i_addr_strap_high_pin,
  input  wire logic [1:0] i_addr_strap_low_pin,
  input  wire logic       i_hold_update,
  input  wire logic       i_blink_enable,
  input  wire logic       i_blink_phase,
  input  wire logic [1:0] i_scan_digit,
  output logic      [6:0] o_scan_char,
  output logic            o_scan_invert,
  output logic      [6:0] o_font_addr
);

  slave_state_type st_r;
  slave_state_type st_nxt;
  logic [5:0]      sync_q;
  logic            scl_s;
  logic            sda_s;
  logic [6:0]      own_addr;
  logic            rise;
  logic            fall;
  logic            start_cond;
  logic            stop_cond;
  logic [7:0]      rd_byte;
  logic            push_valid;
  wr_item_type     push_item;
  logic            buf_in_ready;
  logic            drain_valid;
  logic            drain_fire;
  wr_item_type     drain_item;
  logic [7:0]      scan_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Next pointer; the top pointer bit is carried but never counts
  function automatic logic [7:0] ptr_bump(input logic [7:0] p);
    if (p[6:0] == `PTR_FONT || p[6:0] == `PTR_LAST) begin
      ptr_bump = p;
    end else begin
      ptr_bump = {p[7], p[6:0] + 7'h01};
    end
  endfunction

  // Font pointer moves only while the command pointer is parked on it
  function automatic logic [6:0] font_bump(input logic [7:0] p,
                                           input logic [6:0] f);
    font_bump = (p[6:0] == `PTR_FONT) ? f + 7'h01 : f;
  endfunction

  // Digit bank hit: bit 0 primary plane, bit 1 alternate plane
  function automatic logic [1:0] digit_hit(input logic [7:0] p);
    digit_hit = 2'h0;
    if (p[4:2] == 3'h0) begin
      case (p[6:5])
        `BANK_PRI:  digit_hit = 2'h1;
        `BANK_ALT:  digit_hit = 2'h2;
        `BANK_BOTH: digit_hit = 2'h3;
        default:    digit_hit = 2'h0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus lines and straps are foreign to this clock
  line_sync #(
    .W (6)
  ) u_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   ({i_scl, i_sda, i_addr_strap_high_pin, i_addr_strap_low_pin}),
    .o_q   (sync_q)
  );

  assign scl_s    = sync_q[5];
  assign sda_s    = sync_q[4];
  assign own_addr = {`SLV_ADDR_FIXED, sync_q[3:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Edge and condition detection on the synced lines
  assign rise       = !st_r.scl_d && scl_s;
  assign fall       = st_r.scl_d && !scl_s;
  assign start_cond = st_r.scl_d && scl_s && st_r.sda_d && !sda_s;
  assign stop_cond  = st_r.scl_d && scl_s && !st_r.sda_d && sda_s;

  // Unmapped pointers and the dual-plane window read as zero
  always_comb begin
    case (digit_hit(st_r.ptr))
      2'h1:    rd_byte = st_r.pri[st_r.ptr[1:0]];
      2'h2:    rd_byte = st_r.alt[st_r.ptr[1:0]];
      default: rd_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Written bytes queue here, so a held store loses nothing already taken
  byte_buffer #(
    .WIDTH ($bits(wr_item_type)),
    .DEPTH (2)
  ) u_buf (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_in_valid  (push_valid),
    .o_in_ready  (buf_in_ready),
    .i_in_data   (push_item),
    .o_out_valid (drain_valid),
    .i_out_ready (!i_hold_update),
    .o_out_data  (drain_item)
  );

  assign drain_fire = drain_valid && !i_hold_update;

  // Blink phase picks the plane only when blinking is on
  assign scan_byte = (i_blink_enable && i_blink_phase) ?
                     st_r.alt[i_scan_digit] : st_r.pri[i_scan_digit];

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic load_rd;
    logic [1:0] hit;
    load_rd    = 1'b0;
    hit        = 2'h0;
    st_nxt     = st_r;
    push_valid = 1'b0;
    push_item  = '0;
    st_nxt.scl_d = scl_s;
    st_nxt.sda_d = sda_s;
    if (start_cond) begin
      // Repeated start also lands here
      st_nxt.fsm    = S_ADDR;
      st_nxt.cnt    = 4'h0;
      st_nxt.sda_oe = 1'b0;
    end else if (stop_cond) begin
      st_nxt.fsm    = S_IDLE;
      st_nxt.sda_oe = 1'b0;
    end else begin
      case (st_r.fsm)
        S_IDLE, S_IGNORE: begin
          st_nxt.sda_oe = 1'b0;
        end
        S_ADDR, S_CMD, S_WDATA: begin
          if (rise) begin
            st_nxt.shreg = {st_r.shreg[6:0], sda_s};
            st_nxt.cnt   = st_r.cnt + 4'h1;
          end else if (fall && st_r.cnt == `BITS_PER_BYTE) begin
            st_nxt.cnt = 4'h0;
            if (st_r.fsm == S_ADDR) begin
              if (st_r.shreg[7:1] == own_addr) begin
                st_nxt.rw     = st_r.shreg[0];
                st_nxt.sda_oe = 1'b1;
                st_nxt.fsm    = S_ADDR_ACK;
              end else begin
                st_nxt.fsm = S_IGNORE;
              end
            end else begin
              push_valid       = 1'b1;
              push_item.is_cmd = (st_r.fsm == S_CMD);
              push_item.data   = st_r.shreg;
              // No room means no acknowledge: SCL cannot be stretched
              if (buf_in_ready) begin
                st_nxt.sda_oe = 1'b1;
                st_nxt.fsm    = (st_r.fsm == S_CMD) ? S_CMD_ACK
                                                    : S_WDATA_ACK;
              end else begin
                st_nxt.fsm = S_IGNORE;
              end
            end
          end
        end
        S_ADDR_ACK, S_CMD_ACK, S_WDATA_ACK: begin
          if (fall) begin
            st_nxt.sda_oe = 1'b0;
            if (st_r.fsm == S_ADDR_ACK && st_r.rw) begin
              load_rd = 1'b1;
            end else if (st_r.fsm == S_ADDR_ACK) begin
              st_nxt.fsm = S_CMD;
            end else begin
              st_nxt.fsm = S_WDATA;
            end
          end
        end
        S_RDATA: begin
          if (rise) begin
            st_nxt.cnt = st_r.cnt + 4'h1;
          end else if (fall && st_r.cnt == `BITS_PER_BYTE) begin
            st_nxt.sda_oe = 1'b0;
            st_nxt.fsm    = S_RDATA_ACK;
          end else if (fall) begin
            st_nxt.sda_oe = !st_r.tx[7];
            st_nxt.tx     = {st_r.tx[6:0], 1'b0};
          end
        end
        S_RDATA_ACK: begin
          if (rise) begin
            st_nxt.ack_seen = !sda_s;
          end else if (fall && st_r.ack_seen) begin
            load_rd = 1'b1;
          end else if (fall) begin
            st_nxt.fsm = S_IGNORE;
          end
        end
        default: begin
          st_nxt.fsm    = S_IDLE;
          st_nxt.sda_oe = 1'b0;
        end
      endcase
    end
    // Fetch the pointed byte, put out its first bit, move on
    if (load_rd) begin
      st_nxt.tx       = {rd_byte[6:0], 1'b0};
      st_nxt.sda_oe   = !rd_byte[7];
      st_nxt.cnt      = 4'h0;
      st_nxt.fsm      = S_RDATA;
      st_nxt.ptr      = ptr_bump(st_r.ptr);
      st_nxt.font_ptr = font_bump(st_r.ptr, st_r.font_ptr);
    end
    // Apply queued bytes; a command byte only moves the pointer
    if (drain_fire && drain_item.is_cmd) begin
      st_nxt.ptr = drain_item.data;
    end else if (drain_fire) begin
      hit = digit_hit(st_r.ptr);
      if (hit[0]) begin
        st_nxt.pri[st_r.ptr[1:0]] = drain_item.data;
      end
      if (hit[1]) begin
        st_nxt.alt[st_r.ptr[1:0]] = drain_item.data;
      end
      st_nxt.ptr      = ptr_bump(st_r.ptr);
      st_nxt.font_ptr = font_bump(st_r.ptr, st_r.font_ptr);
    end
    // Character index and inversion flag to the font stage
    st_nxt.scan_char = scan_byte[6:0];
    st_nxt.scan_inv  = scan_byte[7];
    st_nxt.sda_out   = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r          <= '0;
      st_r.fsm      <= S_IDLE;
      st_r.scl_d    <= 1'b1;
      st_r.sda_d    <= 1'b1;
      st_r.ptr      <= `PTR_RST;
      st_r.font_ptr <= `FONT_RST;
      st_r.pri      <= {4{`DIGIT_RST}};
      st_r.alt      <= {4{`DIGIT_RST}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_sda_out     = st_r.sda_out;
  assign o_sda_oe      = st_r.sda_oe;
  assign o_scan_char   = st_r.scan_char;
  assign o_scan_invert = st_r.scan_inv;
  assign o_font_addr   = st_r.font_ptr;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_idle_release;
    (st_r.fsm == S_IDLE) |-> !o_sda_oe;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("SDA driven while idle");

  property p_start_addr;
    start_cond |=> (st_r.fsm == S_ADDR && !o_sda_oe && st_r.cnt == 4'h0);
  endproperty
  a_start_addr: assert property (p_start_addr)
    else $error("start not followed by address phase");

  property p_oe_on_fall;
    $changed(o_sda_oe) |-> $past(fall || start_cond || stop_cond);
  endproperty
  a_oe_on_fall: assert property (p_oe_on_fall)
    else $error("SDA drive changed while SCL high");

  property p_pull_low_only;
    o_sda_out == 1'b0;
  endproperty
  a_pull_low_only: assert property (p_pull_low_only)
    else $error("SDA driven high");

  property p_addr_ack;
    (st_r.fsm == S_ADDR && fall && st_r.cnt == 4'h8 &&
     st_r.shreg[7:1] == own_addr) |=> (o_sda_oe && st_r.fsm == S_ADDR_ACK);
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");

  property p_ignore_release;
    (st_r.fsm == S_ADDR && fall && st_r.cnt == 4'h8 &&
     st_r.shreg[7:1] != own_addr) |=> (!o_sda_oe)[*2];
  endproperty
  a_ignore_release: assert property (p_ignore_release)
    else $error("foreign address acknowledged");

  property p_cmd_ptr;
    (drain_fire && drain_item.is_cmd) |=> st_r.ptr == $past(drain_item.data);
  endproperty
  a_cmd_ptr: assert property (p_cmd_ptr)
    else $error("command byte not stored as pointer");

  property p_font_hold;
    (drain_fire && !drain_item.is_cmd && st_r.ptr[6:0] == 7'h05) |=>
      (st_r.ptr[6:0] == 7'h05 &&
       st_r.font_ptr == $past(st_r.font_ptr) + 7'h01);
  endproperty
  a_font_hold: assert property (p_font_hold)
    else $error("font pointer rule broken");

  property p_both_planes;
    (drain_fire && !drain_item.is_cmd && st_r.ptr[6:2] == 5'h18) |=>
      (st_r.pri[$past(st_r.ptr[1:0])] == $past(drain_item.data) &&
       st_r.alt[$past(st_r.ptr[1:0])] == $past(drain_item.data));
  endproperty
  a_both_planes: assert property (p_both_planes)
    else $error("dual-plane write missed a plane");

  property p_read_bit;
    (st_r.fsm == S_RDATA_ACK && fall && st_r.ack_seen && !start_cond) |=>
      (st_r.fsm == S_RDATA && o_sda_oe == !$past(rd_byte[7]));
  endproperty
  a_read_bit: assert property (p_read_bit)
    else $error("read byte not started");

  property p_scan_primary;
    !i_blink_enable |=>
      ({o_scan_invert, o_scan_char} == $past(st_r.pri[i_scan_digit]));
  endproperty
  a_scan_primary: assert property (p_scan_primary)
    else $error("scan not taken from primary plane");

endmodule

// ===== pkg/matrix_i2c_defs.svh
`ifndef MATRIX_I2C_DEFS_SVH
`define MATRIX_I2C_DEFS_SVH

// Fixed upper bits of the slave address
`define SLV_ADDR_FIXED  3'h5
// Bits moved per byte before the acknowledge clock
`define BITS_PER_BYTE   4'h8
// Pointer values that do not autoincrement
`define PTR_FONT        7'h05
`define PTR_LAST        7'h7F
// Digit bank code in pointer bits 6..5
`define BANK_PRI        2'h1
`define BANK_ALT        2'h2
`define BANK_BOTH       2'h3
// Reset values
`define DIGIT_RST       8'h00
`define PTR_RST         8'h00
`define FONT_RST        7'h00

`endif

// ===== pkg/matrix_i2c_pkg.sv
package matrix_i2c_pkg;

  typedef enum logic [3:0] {
    S_IDLE,
    S_ADDR,
    S_ADDR_ACK,
    S_CMD,
    S_CMD_ACK,
    S_WDATA,
    S_WDATA_ACK,
    S_RDATA,
    S_RDATA_ACK,
    S_IGNORE
  } fsm_type;

  typedef logic [3:0][7:0] plane_type;

  // One received byte on its way to the register store
  typedef struct packed {
    logic       is_cmd;
    logic [7:0] data;
  } wr_item_type;

  typedef struct packed {
    fsm_type    fsm;
    logic       scl_d;
    logic       sda_d;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [3:0] cnt;
    logic       rw;
    logic       ack_seen;
    logic       sda_out;
    logic       sda_oe;
    logic [7:0] ptr;
    logic [6:0] font_ptr;
    plane_type  pri;
    plane_type  alt;
    logic [6:0] scan_char;
    logic       scan_inv;
  } slave_state_type;

endpackage

// ===== design/line_sync.sv
`timescale 1ns/1ps
module line_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  if (W < 1) begin : g_chk
    $error("line_sync width must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two stages; only the second stage leaves the module
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_r <= '1;
      q_r    <= '1;
    end else begin
      meta_r <= i_d;
      q_r    <= meta_r;
    end
  end

  assign o_q = q_r;

endmodule

// ===== design/byte_buffer.sv
`timescale 1ns/1ps
module byte_buffer #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  // Pointers wrap by overflow, so the depth must be a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
    $error("byte_buffer needs a power-of-two depth of two or more");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Honest flags straight from the fill count
  assign o_in_ready  = (cnt_r != DEPTH[AW:0]);
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data  = mem_r[rp_r];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Storage and pointers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        mem_r[wp_r] <= i_in_data;
        wp_r        <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

endmodule

// ===== dv/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  // Both lines released at rest; clock stands still between frames
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Start, or repeated start when the clock is low
  task automatic start_c();
    tick(2);
    if (o_scl === 1'b0) begin
      o_sda <= 1'b1;
      tick(2);
      o_scl <= 1'b1;
      tick(4);
    end
    o_sda <= 1'b0;
    tick(4);
    o_scl <= 1'b0;
  endtask

  // Stop, then a free bus gap
  task automatic stop_c();
    tick(2);
    o_sda <= 1'b0;
    tick(2);
    o_scl <= 1'b1;
    tick(4);
    o_sda <= 1'b1;
    tick(8);
  endtask

  // Data only moves while the clock is low
  task automatic clk_bit(input logic b, output logic s);
    tick(2);
    o_sda <= b;
    tick(2);
    o_scl <= 1'b1;
    tick(2);
    s = i_sda;
    tick(2);
    o_scl <= 1'b0;
  endtask

  // MSB first, then released for the slave's answer
  task automatic tx(input logic [7:0] d, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'b1, ack_n);
  endtask

  // Read byte; the master answers on the ninth clock
  task automatic rx(input logic ack_n, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(ack_n, s);
  endtask
endmodule

// ===== dv/matrix_display_i2c_slave_regs_test.sv
`timescale 1ns/1ps
module matrix_display_i2c_slave_regs_test;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       m_scl;
  logic       m_sda;
  logic       sda_out;
  logic       sda_oe;
  wire        bus_sda;
  logic [1:0] strap_hi = 2'h0;
  logic [1:0] strap_lo = 2'h0;
  logic       hold = 1'b0;
  logic       blink_en = 1'b0;
  logic       blink_ph = 1'b0;
  logic [1:0] scan_digit = 2'h0;
  logic [6:0] scan_char;
  logic       scan_inv;
  logic [6:0] font_addr;
  logic [6:0] me = 7'h5F;
  int         failures = 0;
  int         checked = 0;

  always #10 clk = ~clk;

  // Open-drain wire with pull-up: low if either party pulls
  assign bus_sda = m_sda & (sda_oe ? sda_out : 1'b1);

  i2c_master_model mst_u (
    .i_clk (clk),
    .i_sda (bus_sda),
    .o_scl (m_scl),
    .o_sda (m_sda)
  );

  matrix_i2c_slave dut_u (
    .i_clk                 (clk),
    .i_rst                 (rst),
    .i_scl                 (m_scl),
    .i_sda                 (bus_sda),
    .o_sda_out             (sda_out),
    .o_sda_oe              (sda_oe),
    .i_addr_strap_high_pin (strap_hi),
    .i_addr_strap_low_pin  (strap_lo),
    .i_hold_update         (hold),
    .i_blink_enable        (blink_en),
    .i_blink_phase         (blink_ph),
    .i_scan_digit          (scan_digit),
    .o_scan_char           (scan_char),
    .o_scan_invert         (scan_inv),
    .o_font_addr           (font_addr)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string w, input logic [7:0] e,
                     input logic [7:0] g);
    checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", w, e, g);
      failures++;
    end
  endtask

  // Start plus address byte, acknowledge judged
  task automatic addr_ph(input logic [6:0] a, input logic rw,
                         input logic en);
    logic n;
    mst_u.start_c();
    mst_u.tx({a, rw}, n);
    chk("address ack", {7'h0, en}, {7'h0, n});
  endtask

  task automatic put(input logic [7:0] d, input logic en);
    logic n;
    mst_u.tx(d, n);
    chk("write ack", {7'h0, en}, {7'h0, n});
  endtask

  task automatic get(input logic an, input logic [7:0] e);
    logic [7:0] d;
    mst_u.rx(an, d);
    chk("read byte", e, d);
  endtask

  // Scan lookup; result registered one cycle after the inputs
  task automatic scan_chk(input logic [1:0] dg, input logic en,
                          input logic ph, input logic [7:0] e);
    @(posedge clk);
    scan_digit <= dg;
    blink_en <= en;
    blink_ph <= ph;
    repeat (3) @(posedge clk);
    chk("scan digit", e, {scan_inv, scan_char});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Every strap code; a neighbour's address stays unanswered
  task automatic sc_straps();
    logic [3:0] k;
    for (int i = 0; i < 16; i++) begin
      k = 4'(i);
      @(posedge clk);
      strap_hi <= k[3:2];
      strap_lo <= k[1:0];
      mst_u.tick(6);
      addr_ph({3'h5, k}, 1'b0, 1'b0);
      mst_u.stop_c();
      addr_ph({3'h5, k ^ 4'h1}, 1'b0, 1'b1);
      chk("released", 8'h00, {7'h0, sda_oe});
      mst_u.stop_c();
    end
  endtask

  // Pointer with bit 7 set, a lost byte, then the four primary digits
  task automatic sc_write();
    logic [7:0] ex[4] = '{8'h41, 8'hC2, 8'h03, 8'h7F};
    addr_ph(me, 1'b0, 1'b0);
    put(8'h9F, 1'b0);
    put(8'h55, 1'b0);
    for (int i = 0; i < 4; i++) begin
      put(ex[i], 1'b0);
    end
    put(8'h66, 1'b0);
    mst_u.stop_c();
    for (int i = 0; i < 4; i++) begin
      scan_chk(2'(i), 1'b0, 1'b1, ex[i]);
    end
  endtask

  // Alternate plane alone, then both planes at once
  task automatic sc_planes();
    addr_ph(me, 1'b0, 1'b0);
    put(8'h42, 1'b0);
    put(8'h11, 1'b0);
    addr_ph(me, 1'b0, 1'b0);
    put(8'h63, 1'b0);
    put(8'h99, 1'b0);
    mst_u.stop_c();
    scan_chk(2'h2, 1'b1, 1'b1, 8'h11);
    scan_chk(2'h2, 1'b1, 1'b0, 8'h03);
    scan_chk(2'h3, 1'b1, 1'b1, 8'h99);
    scan_chk(2'h3, 1'b0, 1'b0, 8'h99);
    scan_chk(2'h1, 1'b1, 1'b1, 8'h00);
  endtask

  // Pointer write, repeated start, multi-byte read, master NACK
  task automatic sc_read();
    addr_ph(me, 1'b0, 1'b0);
    put(8'h21, 1'b0);
    addr_ph(me, 1'b1, 1'b0);
    get(1'b0, 8'hC2);
    get(1'b0, 8'h03);
    get(1'b0, 8'h99);
    get(1'b1, 8'h00);
    get(1'b1, 8'hFF);
    mst_u.stop_c();
    addr_ph(me, 1'b0, 1'b0);
    put(8'h42, 1'b0);
    mst_u.stop_c();
    scan_chk(2'h2, 1'b1, 1'b1, 8'h11);
    addr_ph(me, 1'b1, 1'b0);
    get(1'b0, 8'h11);
    get(1'b1, 8'h99);
    mst_u.stop_c();
    addr_ph(me, 1'b0, 1'b0);
    put(8'h61, 1'b0);
    addr_ph(me, 1'b1, 1'b0);
    get(1'b1, 8'h00);
    mst_u.stop_c();
  endtask

  // Pointer parks on the font register while the font pointer moves
  task automatic sc_font();
    addr_ph(me, 1'b0, 1'b0);
    put(8'h05, 1'b0);
    put(8'h01, 1'b0);
    put(8'h02, 1'b0);
    mst_u.stop_c();
    chk("font pointer", 8'h02, {1'b0, font_addr});
    addr_ph(me, 1'b1, 1'b0);
    get(1'b1, 8'h00);
    mst_u.stop_c();
    chk("font pointer", 8'h03, {1'b0, font_addr});
  endtask

  // Stalled drain: two entries fit, the third byte is refused
  task automatic sc_hold();
    @(posedge clk);
    hold <= 1'b1;
    addr_ph(me, 1'b0, 1'b0);
    put(8'h21, 1'b0);
    put(8'h5A, 1'b0);
    put(8'h6B, 1'b1);
    mst_u.stop_c();
    scan_chk(2'h1, 1'b0, 1'b0, 8'hC2);
    @(posedge clk);
    hold <= 1'b0;
    scan_chk(2'h1, 1'b0, 1'b0, 8'h5A);
    scan_chk(2'h2, 1'b0, 1'b0, 8'h03);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watchdog against a hung run
  initial begin
    repeat (100000) @(posedge clk);
    $display("[FAIL] watchdog expected end seen hang");
    failures++;
    conclude();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    chk("idle oe", 8'h00, {7'h0, sda_oe});
    scan_chk(2'h0, 1'b1, 1'b1, 8'h00);
    chk("font reset", 8'h00, {1'b0, font_addr});
    sc_straps();
    sc_write();
    sc_planes();
    sc_read();
    sc_font();
    sc_hold();
    conclude();
  end
endmodule
